//--- bridge_adc_result_multisample.sv
// Bridge result, module status and locked multisample slots
//
// How it works
// R1 - Invalid result sets bit 0, value 0xFF800000
// R2 - Bit 2 low only while locked to bus
// R3 - Signed 24-bit result in 32-bit word
// R4 - Code -8388608 reserved for negative invalid
// R5 - Underflow clamps to -8388607, valid range inside
// R6 - Overflow or open gives 8388607, open bit
// R7 - Decode 3-bit range, upper bits zero
// R8 - Cycle byte: 0 is 50us, 1 100us
// R9 - Bus cycle must be converter period multiple
// R10 - Converter period fixed, locked to bus cycle
// R11 - Multisampling offered on channel one only
// R12 - Three to ten sample slots per cycle
// R13 - Excess conversions drop oldest, keep newest ten
// R14 - Unsynchronised cycle outputs invalid code 0x8000
// R15 - Unfilled slots carry invalid code 0x8000
// R16 - Controller should disable unused slots
// R17 - Each slot carries 16-bit raw result
// R18 - Open bit clears itself when measurements recover
// R19 - Status bits 3 to 7 read zero
`timescale 1ns/1ps
module bridge_adc_result_multisample
  import bridge_adc_pkg::*;
#(
  parameter int CONV_SHORT_CYCLES = CONV_SHORT_CYC_DEF,
  parameter int CONV_LONG_CYCLES  = CONV_LONG_CYC_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        bus_cycle_start,
  input  wire logic        conv_valid,
  input  wire conv_t       conv_data,
  output logic             conv_ready,
  output logic             conv_start,
  input  wire logic        bridge_supply_fault,
  input  wire logic        io_supply_fault,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       multisample_range_config,
  output logic [7:0]       multisample_cycle_select,
  output logic [8:0]       range_mvv_out,
  output logic [7:0]       module_status,
  output logic [31:0]      bridge_raw_value,
  output slots_t           sample_slot_n,
  output logic [SLOT_CNT_W-1:0] slot_fill
);

  logic [7:0]            range_cfg_r;
  logic [7:0]            cycle_sel_r;
  logic                  cfg_changed_r;
  logic [8:0]            range_mvv_r;
  logic                  configured;
  logic                  invalid_now;
  logic [CNT_W-1:0]      period_cyc;
  logic [CNT_W-1:0]      phase_r;
  logic                  tick;
  logic                  aligned;
  logic                  conv_start_r;
  sync_state_t           sync_r;
  sync_state_t           sync_nxt;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  conv_t                 fifo_out_data;
  logic                  pop;
  slots_t                win_r;
  logic [SLOT_CNT_W-1:0] win_cnt_r;
  slots_t                slots_r;
  logic [SLOT_CNT_W-1:0] slot_fill_r;
  logic                  open_seen_r;
  logic [7:0]            status_r;
  logic [31:0]           raw_r;
  logic signed [31:0]    raw_ext;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      range_cfg_r   <= RANGE_RESET;
      cycle_sel_r   <= CYC_SEL_50US;
      cfg_changed_r <= 1'b0;
    end else begin
      cfg_changed_r <= cfg_wr;
      if (cfg_wr && cfg_addr == CFG_ADDR_RANGE) begin
        range_cfg_r <= cfg_wdata;
      end
      if (cfg_wr && cfg_addr == CFG_ADDR_CYCLE) begin
        cycle_sel_r <= cfg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      range_mvv_r <= '0;
    end else begin
      range_mvv_r <= range_mvv(range_cfg_r[RANGE_CODE_W-1:0]); // [R7]
    end
  end

  // Reserved range bits or cycle codes leave the converter unconfigured
  assign configured  = (range_cfg_r[7:RANGE_CODE_W] == '0) && (cycle_sel_r <= CYC_SEL_100US); // [R7] [R8]
  assign invalid_now = bridge_supply_fault || io_supply_fault || !configured; // [R1]
  assign period_cyc  = (cycle_sel_r == CYC_SEL_100US) ? CNT_W'(CONV_LONG_CYCLES)
                                                      : CNT_W'(CONV_SHORT_CYCLES); // [R8]

  // ----------------------------------------------------------------
  // Converter period, restarted by each bus cycle
  // ----------------------------------------------------------------
  assign tick    = (phase_r == period_cyc - 1'b1);
  assign aligned = bus_cycle_start && tick; // [R9]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_r <= '0;
    end else if (cfg_changed_r || bus_cycle_start || tick) begin
      phase_r <= '0; // [R10]
    end else begin
      phase_r <= phase_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= tick && configured; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Lock tracking
  // ----------------------------------------------------------------
  always_comb begin
    sync_nxt = sync_r;
    if (cfg_changed_r) begin
      sync_nxt = SYNC_ACQ;
    end else if (bus_cycle_start) begin
      case (sync_r)
        SYNC_ACQ:    sync_nxt = SYNC_SETTLE;
        SYNC_SETTLE: sync_nxt = aligned ? SYNC_LOCKED : SYNC_SETTLE; // [R14]
        SYNC_LOCKED: sync_nxt = aligned ? SYNC_LOCKED : SYNC_SETTLE; // [R14]
        default:     sync_nxt = SYNC_ACQ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_r <= SYNC_ACQ;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer, drain stalls on the publish cycle
  // ----------------------------------------------------------------
  sample_fifo #(
    .WIDTH (CONV_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (conv_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (conv_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !bus_cycle_start;
  assign pop            = fifo_out_valid && fifo_out_ready;
  assign conv_ready     = fifo_in_ready;

  // ----------------------------------------------------------------
  // Sample window of the running bus cycle, single channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_r     <= '0;
      win_cnt_r <= '0;
    end else if (bus_cycle_start) begin
      win_cnt_r <= '0;
    end else if (pop) begin
      if (win_cnt_r < SLOT_CNT_W'(SLOT_N)) begin
        win_r[win_cnt_r] <= to_sample(fifo_out_data, invalid_now); // [R11] [R17]
        win_cnt_r        <= win_cnt_r + 1'b1; // [R12]
      end else begin
        win_r <= {to_sample(fifo_out_data, invalid_now), win_r[SLOT_N-1:1]}; // [R13]
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot publication at the bus cycle start
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slots_r     <= {SLOT_N{SAMPLE_INVALID}};
      slot_fill_r <= '0;
    end else if (bus_cycle_start) begin
      for (int i = 0; i < SLOT_N; i++) begin
        if (sync_nxt == SYNC_LOCKED && SLOT_CNT_W'(i) < win_cnt_r) begin
          slots_r[i] <= win_r[i]; // [R12]
        end else begin
          slots_r[i] <= SAMPLE_INVALID; // [R14] [R15]
        end
      end
      slot_fill_r <= (sync_nxt == SYNC_LOCKED) ? win_cnt_r : '0; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Raw 24-bit value
  // ----------------------------------------------------------------
  assign raw_ext = 32'(signed'(fifo_out_data.code)); // [R3]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      raw_r <= RAW_INVALID;
    end else if (invalid_now) begin
      raw_r <= RAW_INVALID; // [R1]
    end else if (pop) begin
      if (fifo_out_data.open || fifo_out_data.over || raw_ext >= signed'(RAW_POS_FS)) begin
        raw_r <= RAW_POS_FS; // [R6]
      end else if (fifo_out_data.under || raw_ext <= signed'(RAW_NEG_FS)) begin
        raw_r <= RAW_NEG_FS; // [R4] [R5]
      end else begin
        raw_r <= raw_ext; // [R3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Module status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      open_seen_r <= 1'b0;
    end else if (pop && fifo_out_data.open) begin
      open_seen_r <= 1'b1;
    end else if (bus_cycle_start) begin
      open_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r                   <= '0; // [R19]
      status_r[STAT_INVALID_BIT] <= invalid_now; // [R1]
      status_r[STAT_NOSYNC_BIT]  <= (sync_nxt != SYNC_LOCKED); // [R2]
      if (pop && fifo_out_data.open) begin
        status_r[STAT_OPEN_BIT] <= 1'b1; // [R6]
      end else if (bus_cycle_start && !open_seen_r) begin
        status_r[STAT_OPEN_BIT] <= 1'b0; // [R18]
      end else begin
        status_r[STAT_OPEN_BIT] <= status_r[STAT_OPEN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign multisample_range_config = range_cfg_r;
  assign multisample_cycle_select = cycle_sel_r;
  assign range_mvv_out            = range_mvv_r;
  assign conv_start               = conv_start_r;
  assign module_status            = status_r;
  assign bridge_raw_value         = raw_r;
  assign sample_slot_n            = slots_r;
  assign slot_fill                = slot_fill_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_INVALID_RAW: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    invalid_now |=> status_r[STAT_INVALID_BIT] && raw_r == RAW_INVALID)
    else $error("invalid result not reported");

  AST_NOSYNC_BIT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
    status_r[STAT_NOSYNC_BIT] == (sync_r != SYNC_LOCKED))
    else $error("sync status bit disagrees with lock state");

  AST_SIGN_EXT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
    raw_r[31:RAW_W-1] == '0 || raw_r[31:RAW_W-1] == '1)
    else $error("raw value exceeds 24-bit signed range");

  AST_RESERVED_CODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
    raw_r == RAW_INVALID |-> $past(invalid_now) || $past(raw_r) == RAW_INVALID)
    else $error("reserved code without invalid cause");

  AST_OPEN_FS: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    pop && fifo_out_data.open && !invalid_now |=> raw_r == RAW_POS_FS && status_r[STAT_OPEN_BIT])
    else $error("open circuit not reported");

  AST_OPEN_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R18]
    bus_cycle_start && !open_seen_r |=> !status_r[STAT_OPEN_BIT])
    else $error("open bit did not clear");

  AST_TICK_SPACING: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
    conv_start_r |=> !conv_start_r [*2])
    else $error("converter start too close");

  AST_UNSYNC_SLOTS: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R14]
    bus_cycle_start && sync_nxt != SYNC_LOCKED |=> slots_r == {SLOT_N{SAMPLE_INVALID}} && slot_fill_r == '0)
    else $error("unsynchronised slots not invalid");

  AST_WIN_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
    win_cnt_r <= SLOT_CNT_W'(SLOT_N))
    else $error("window count above slot count");

  AST_STATUS_RSVD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R19]
    status_r[7:3] == '0)
    else $error("reserved status bits set");

  AST_MISALIGNED_START: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R14]
    bus_cycle_start && !aligned |=> status_r[STAT_NOSYNC_BIT])
    else $error("misaligned bus cycle reported as locked");

  AST_PUBLISH_FILL: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
    bus_cycle_start && sync_nxt == SYNC_LOCKED |=> slot_fill_r == $past(win_cnt_r))
    else $error("published fill differs from window count");

  AST_PAD_LAST_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
    bus_cycle_start |=> slots_r[SLOT_N-1] == SAMPLE_INVALID || slot_fill_r == SLOT_CNT_W'(SLOT_N))
    else $error("unfilled last slot not invalid");

  AST_CFG_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
    cfg_changed_r |=> sync_r == SYNC_ACQ && phase_r == '0)
    else $error("config write did not restart lock");

  AST_UNCONF_NO_START: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    !configured |=> !conv_start_r)
    else $error("converter started while unconfigured");

endmodule : bridge_adc_result_multisample

//--- bridge_adc_pkg.sv
// Shared constants, types and helpers for the bridge result and multisample path
package bridge_adc_pkg;

  // ----------------------------------------------------------------
  // Clock and converter timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int NS_PER_US          = 1000;
  localparam int CONV_SHORT_US      = 50;
  localparam int CONV_LONG_US       = 100;
  localparam int CONV_SHORT_CYC_DEF = (CONV_SHORT_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int CONV_LONG_CYC_DEF  = (CONV_LONG_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int CNT_W              = 14;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int RAW_W      = 24;
  localparam int SAMPLE_W   = 16;
  localparam int SLOT_N     = 10;
  localparam int SLOT_CNT_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CONV_W     = RAW_W + 3;
  localparam int SAMPLE_LSB = RAW_W - SAMPLE_W;

  // ----------------------------------------------------------------
  // Result codes
  // ----------------------------------------------------------------
  localparam logic [31:0]         RAW_INVALID   = 32'hFF800000;
  localparam logic [31:0]         RAW_NEG_FS    = 32'hFF800001;
  localparam logic [31:0]         RAW_POS_FS    = 32'h007FFFFF;
  localparam logic [SAMPLE_W-1:0] SAMPLE_INVALID = 16'h8000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_NEG_FS  = 16'h8001;

  // ----------------------------------------------------------------
  // Status and configuration fields
  // ----------------------------------------------------------------
  localparam int          STAT_INVALID_BIT = 0;
  localparam int          STAT_OPEN_BIT    = 1;
  localparam int          STAT_NOSYNC_BIT  = 2;
  localparam logic [7:0]  STATUS_RESET     = 8'h05;
  localparam int          RANGE_CODE_W     = 3;
  localparam logic [7:0]  RANGE_RESET      = 8'h00;
  localparam logic [7:0]  CYC_SEL_50US     = 8'h00;
  localparam logic [7:0]  CYC_SEL_100US    = 8'h01;
  localparam logic        CFG_ADDR_RANGE   = 1'b0;
  localparam logic        CFG_ADDR_CYCLE   = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [RAW_W-1:0] code;
    logic             over;
    logic             under;
    logic             open;
  } conv_t;

  typedef logic [SLOT_N-1:0][SAMPLE_W-1:0] slots_t;

  typedef enum logic [1:0] {
    SYNC_ACQ    = 2'b00,
    SYNC_SETTLE = 2'b01,
    SYNC_LOCKED = 2'b11
  } sync_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] range_mvv(input logic [RANGE_CODE_W-1:0] code);
    case (code)
      3'h0:    range_mvv = 9'h010;
      3'h1:    range_mvv = 9'h008;
      3'h2:    range_mvv = 9'h004;
      3'h3:    range_mvv = 9'h002;
      3'h4:    range_mvv = 9'h100;
      3'h5:    range_mvv = 9'h080;
      3'h6:    range_mvv = 9'h040;
      default: range_mvv = 9'h020;
    endcase
  endfunction : range_mvv

  function automatic logic [SAMPLE_W-1:0] to_sample(input conv_t c, input logic bad);
    logic [SAMPLE_W-1:0] s;
    s = c.code[RAW_W-1:SAMPLE_LSB];
    if (bad) begin
      to_sample = SAMPLE_INVALID;
    end else if (s == SAMPLE_INVALID) begin
      to_sample = SAMPLE_NEG_FS;
    end else begin
      to_sample = s;
    end
  endfunction : to_sample

endpackage : bridge_adc_pkg

//--- sample_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0]   count_r;
  logic [PTR_W:0]   count_nxt;
  logic             full_r;
  logic             empty_r;
  logic             push;
  logic             pop;

  assign push      = in_valid && !full_r;
  assign pop       = out_ready && !empty_r;
  assign in_ready  = !full_r;
  assign out_valid = !empty_r;
  assign out_data  = mem_r[rd_ptr_r];

  // ----------------------------------------------------------------
  // Occupancy
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_r <= '0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      count_r <= count_nxt;
      full_r  <= (count_nxt == (PTR_W+1)'(DEPTH));
      empty_r <= (count_nxt == '0);
    end
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule : sample_fifo

//--- conv_model.sv
// Converter front end model answering start pulses with results
`timescale 1ns/1ps
module conv_model
  import bridge_adc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        conv_start,
  input  wire logic        conv_ready,
  input  wire logic [23:0] code_in,
  input  wire logic [2:0]  flags_in,
  input  wire logic        step_en,
  input  wire logic [3:0]  delay_in,
  output logic             conv_valid,
  output conv_t            conv_data,
  output logic [15:0]      sent
);
  // ----------------------------------------------------------------
  // Start, delay, offer and hold until taken
  // ----------------------------------------------------------------
  logic       pend_r;
  logic [3:0] wait_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_r     <= 1'b0;
      wait_r     <= 4'h0;
      conv_valid <= 1'b0;
      conv_data  <= '0;
      sent       <= 16'h0000;
    end else begin
      if (conv_start) begin
        pend_r <= 1'b1;
        wait_r <= delay_in;
      end else if (pend_r && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (pend_r && !conv_valid) begin
        pend_r     <= 1'b0;
        conv_valid <= 1'b1;
        conv_data  <= {code_in + (step_en ? {sent, 8'h00} : 24'h0), flags_in};
      end
      if (conv_valid && conv_ready) begin
        conv_valid <= 1'b0;
        conv_data  <= ~conv_data;
        sent       <= sent + 16'h0001;
      end
    end
  end
endmodule : conv_model

//--- tb_top.sv
// Self-checking testbench for the bridge result and multisample path
`timescale 1ns/1ps
module tb_top;
  import bridge_adc_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  logic        bus_cycle_start;
  logic        conv_valid;
  conv_t       conv_data;
  logic        conv_ready;
  logic        conv_start;
  logic        bridge_supply_fault;
  logic        io_supply_fault;
  logic        cfg_wr;
  logic        cfg_addr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  range_cfg;
  logic [7:0]  cyc_sel;
  logic [8:0]  mvv;
  logic [7:0]  status;
  logic [31:0] raw;
  slots_t      slots;
  logic [3:0]  fill;
  logic [23:0] code_in;
  logic [2:0]  flags_in;
  logic        step_en;
  logic [3:0]  delay_in;
  logic [15:0] sent;
  int          fails;
  int          num_checks;

  bridge_adc_result_multisample #(.CONV_SHORT_CYCLES(8), .CONV_LONG_CYCLES(16)) bridge_adc_result_multisample_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_cycle_start(bus_cycle_start), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready), .conv_start(conv_start),
    .bridge_supply_fault(bridge_supply_fault), .io_supply_fault(io_supply_fault), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .multisample_range_config(range_cfg),
    .multisample_cycle_select(cyc_sel), .range_mvv_out(mvv), .module_status(status),
    .bridge_raw_value(raw), .sample_slot_n(slots), .slot_fill(fill));

  conv_model conv_model_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .conv_start(conv_start), .conv_ready(conv_ready), .code_in(code_in),
    .flags_in(flags_in), .step_en(step_en), .delay_in(delay_in), .conv_valid(conv_valid),
    .conv_data(conv_data), .sent(sent));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    close_out();
  end

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic cfg_write(input logic a, input logic [7:0] d);
    cfg_wr    = 1'b1;
    cfg_addr  = a;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask : cfg_write

  task automatic bus_starts(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      bus_cycle_start = 1'b1;
      cyc(1);
      bus_cycle_start = 1'b0;
      cyc(1);
      if (i < n - 1) cyc(gap - 2);
    end
  endtask : bus_starts

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_range();
    logic [8:0] tbl [8] = '{9'd16, 9'd8, 9'd4, 9'd2, 9'd256, 9'd128, 9'd64, 9'd32};
    for (int c = 0; c < 8; c++) begin
      cfg_write(1'b0, 8'(c));
      cyc(2);
      check_val("range_mvv", {23'h0, tbl[c]}, {23'h0, mvv});
      check_val("range_cfg", 32'(c), {24'h0, range_cfg});
    end
    cfg_write(1'b0, 8'h08);
    cyc(4);
    check_val("bad_range_inv", 32'h1, {31'h0, status[0]});
    check_val("bad_range_raw", 32'hFF800000, raw);
    cfg_write(1'b0, 8'h00);
    cfg_write(1'b1, 8'h02);
    cyc(4);
    check_val("cyc_sel", 32'h2, {24'h0, cyc_sel});
    check_val("bad_cyc_inv", 32'h1, {31'h0, status[0]});
    cfg_write(1'b1, 8'h00);
  endtask : t_range

  task automatic t_faults();
    for (int f = 0; f < 2; f++) begin
      cyc(24);
      check_val("good_inv", 32'h0, {31'h0, status[0]});
      bridge_supply_fault = (f == 0);
      io_supply_fault     = (f == 1);
      cyc(4);
      check_val("fault_inv", 32'h1, {31'h0, status[0]});
      check_val("fault_raw", 32'hFF800000, raw);
      bridge_supply_fault = 1'b0;
      io_supply_fault     = 1'b0;
    end
  endtask : t_faults

  task automatic t_raw();
    logic [23:0] rc [8] = '{24'h000123, 24'h7FFFFE, 24'h7FFFFF, 24'h800000, 24'h800001, 24'h800002,
                            24'h000010, 24'h000010};
    logic [2:0]  rf [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2};
    logic [31:0] rx [8] = '{32'h00000123, 32'h007FFFFE, 32'h007FFFFF, 32'hFF800001, 32'hFF800001,
                            32'hFF800002, 32'h007FFFFF, 32'hFF800001};
    for (int i = 0; i < 8; i++) begin
      code_in  = rc[i];
      flags_in = rf[i];
      cyc(24);
      check_val("raw", rx[i], raw);
      check_val("raw_inv", 32'h0, {31'h0, status[0]});
      check_val("status_hi", 32'h0, {27'h0, status[7:3]});
    end
  endtask : t_raw

  task automatic t_open();
    flags_in = 3'h1;
    cyc(24);
    check_val("open_raw", 32'h007FFFFF, raw);
    check_val("open_bit", 32'h1, {31'h0, status[1]});
    flags_in = 3'h0;
    cyc(24);
    bus_starts(2, 32);
    check_val("open_clear", 32'h0, {31'h0, status[1]});
  endtask : t_open

  task automatic t_multi(input logic [7:0] sel, input int gap, input int kf, input logic [3:0] dl);
    cfg_write(1'b1, sel);
    code_in  = 24'h0;
    delay_in = dl;
    step_en  = 1'b1;
    bus_starts(4, gap);
    check_val("fill", 32'(kf), {28'h0, fill});
    check_val("locked", 32'h0, {31'h0, status[2]});
    for (int i = 0; i < 10; i++) begin
      if (i < kf) begin
        check_val("slot", {16'h0, sent - 16'(kf - i)}, {16'h0, slots[i]});
      end else begin
        check_val("slot_pad", 32'h8000, {16'h0, slots[i]});
      end
    end
  endtask : t_multi

  task automatic t_nosync();
    cfg_write(1'b1, 8'h00);
    bus_starts(4, 28);
    check_val("nosync_bit", 32'h1, {31'h0, status[2]});
    check_val("nosync_fill", 32'h0, {28'h0, fill});
    for (int i = 0; i < 10; i++) begin
      check_val("nosync_slot", 32'h8000, {16'h0, slots[i]});
    end
  endtask : t_nosync

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails               = 0;
    num_checks          = 0;
    rst_n               = 1'b0;
    bus_cycle_start     = 1'b0;
    bridge_supply_fault = 1'b0;
    io_supply_fault     = 1'b0;
    cfg_wr              = 1'b0;
    cfg_addr            = 1'b0;
    cfg_wdata           = 8'h00;
    code_in             = 24'h0;
    flags_in            = 3'h0;
    step_en             = 1'b0;
    delay_in            = 4'h0;
    cyc(10);
    check_val("rst_status", 32'h05, {24'h0, status});
    check_val("rst_raw", 32'hFF800000, raw);
    check_val("rst_fill", 32'h0, {28'h0, fill});
    check_val("rst_slot", 32'h8000, {16'h0, slots[0]});
    check_val("rst_cyc", 32'h0, {24'h0, cyc_sel});
    check_val("rst_ready", 32'h1, {31'h0, conv_ready});
    check_val("rst_start", 32'h0, {31'h0, conv_start});
    rst_n = 1'b1;
    t_range();
    t_faults();
    t_raw();
    t_open();
    t_multi(8'h00, 32, 4, 4'h0);
    t_multi(8'h00, 80, 10, 4'h0);
    t_multi(8'h00, 104, 10, 4'h2);
    t_multi(8'h01, 48, 3, 4'h3);
    t_nosync();
    close_out();
  end
endmodule : tb_top
